/* File: dv/gsrp_chk.sv */
// concurrent checks on the two-wire link between host and device
`timescale 1ns/10ps
module gsrp_chk (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic host_scl_oe,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // ==================================================
   // bus conditions
   sequence s_start;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence s_stop;
      scl && $past(scl) && $rose(sda);
   endsequence

   // ==================================================
   // link rules
   AST_IDLE_HIGH: assert property ($rose(rst_n) |-> scl && sda)
      else $error("bus lines not released after reset");
   AST_DEV_STABLE_HI: assert property (
      scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device moved data while clock high");
   // both ends may not pull data at once while the clock is high
   AST_NO_CLASH: assert property (
      scl |-> !(host_sda_oe && dev_sda_oe))
      else $error("both ends pull data while clock high");
   AST_START_DEV_QUIET: assert property (s_start |-> !dev_sda_oe)
      else $error("device took part in a start");
   AST_STOP_DEV_QUIET: assert property (
      s_stop |-> !dev_sda_oe ##1 !dev_sda_oe [*4])
      else $error("device drives data after a stop");
   AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*6])
      else $error("clock high phase too short");
   AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*8])
      else $error("clock low phase too short");
   AST_START_CLOCKS: assert property (s_start |-> ##[1:60] !scl)
      else $error("no clock after start");
endmodule

/* File: dv/testbench.sv */
// self-checking bench joining host and device over the two-wire link
`timescale 1ns/10ps
`include "gsrp_defs.svh"
module testbench
   import gsrp_pkg::*;
;
   // arbitrary part code for the bench
   localparam logic [1:0] TB_PART = 2'h3;
   logic       clock, rst_n, por_ok, cmd_wr, cmd_rd, ext_wr, active;
   logic [5:0] fw_level;
   logic [2:0] cmd_addr;
   logic [7:0] cmd_wdata, cmd_rdata, ext_addr, ext_wdata, ext_rdata;
   logic [7:0] mem [256];
   logic [7:0] mon_byte;
   logic       mon_ack, scl_d;
   int         num_errors, n_checks, mon_bits, per_cnt, min_per;

   gsrp_if bus ();
   gsrp_if bus2 ();
   gsrp_host i_gsrp_host (.clock(clock), .rst_n(rst_n), .bus(bus),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
   gsrp_device #(.PART_ID(TB_PART)) i_gsrp_device (.clock(clock),
      .rst_n(rst_n), .bus(bus), .por_ok(por_ok), .fw_level(fw_level),
      .ext_rdata(ext_rdata), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .ext_wr(ext_wr), .active(active));
   // second device faced by a hand-driven master for address faults
   gsrp_device #(.PART_ID(TB_PART)) i_gsrp_device2 (.clock(clock),
      .rst_n(rst_n), .bus(bus2), .por_ok(1'b1), .fw_level(fw_level),
      .ext_rdata(8'h00), .ext_addr(), .ext_wdata(), .ext_wr(),
      .active());
   gsrp_chk i_gsrp_chk (.clock(clock), .rst_n(rst_n),
      .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
      .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));

   // ==================================================
   // clock, register model, wire monitors
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i);
   assign ext_rdata = mem[ext_addr];
   always @(posedge clock) if (ext_wr === 1'b1) mem[ext_addr] <= ext_wdata;
   always @(negedge bus.sda) if (bus.scl === 1'b1) mon_bits = 0;
   always @(posedge bus.scl) begin
      if (mon_bits < 8) mon_byte = {mon_byte[6:0], bus.sda};
      if (mon_bits == 8) mon_ack = bus.sda;
      mon_bits = mon_bits + 1;
   end
   // shortest clock period seen, in cycles minus one
   always @(posedge clock) begin
      scl_d <= bus.scl;
      per_cnt <= per_cnt + 1;
      if (bus.scl && !scl_d) begin
         per_cnt <= 0;
         if (per_cnt < min_per) min_per <= per_cnt;
      end
   end

   // ==================================================
   // shared tasks
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge clock);
      cmd_wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge clock);
      cmd_rd <= 1'b0;
      @(negedge clock);
      d = cmd_rdata;
      @(posedge clock);
   endtask
   task automatic wait_idle(output logic [7:0] st);
      for (int i = 0; i < 5000; i++) begin
         sw_rd(`GSRP_H_STATUS, st);
         if (st[0] === 1'b0) return;
      end
      chk("busy wait", 8'h00, 8'h01);
      close_out();
   endtask
   task automatic link_wr(input logic [7:0] p, input logic [7:0] d,
                          output logic [7:0] st);
      sw_wr(`GSRP_H_PTR, p);
      sw_wr(`GSRP_H_WDATA, d);
      sw_wr(`GSRP_H_CMD, 8'h01);
      wait_idle(st);
   endtask
   task automatic link_rd(input logic [7:0] p, output logic [7:0] d,
                          output logic [7:0] st);
      sw_wr(`GSRP_H_PTR, p);
      sw_wr(`GSRP_H_CMD, 8'h02);
      wait_idle(st);
      sw_rd(`GSRP_H_RDATA, d);
   endtask
   // one quarter of a standard bit on the hand-driven link
   task automatic bb(input logic c, input logic d);
      bus2.host_scl_oe <= ~c;
      bus2.host_sda_oe <= ~d;
      repeat (25) @(posedge clock);
   endtask

   // ==================================================
   // scenarios
   task automatic t_reset();
      chk("lines idle", 8'h03, {6'h0, bus.scl, bus.sda});
      chk("dev drive", 8'h00, {7'h0, bus.dev_sda_oe});
      chk("active", 8'h00, {7'h0, active});
   endtask
   task automatic t_por();
      logic [7:0] st;
      link_wr(8'h30, 8'h77, st);
      chk("nack no por", 8'h02, {6'h0, st[1:0]});
      chk("reg no por", 8'h30, mem[8'h30]);
      por_ok <= 1'b1;
      repeat (10) @(posedge clock);
   endtask
   task automatic t_fw(input logic [7:0] exp);
      logic [7:0] st, d;
      link_rd(`GSRP_OFF_FWREV, d, st);
      chk("fw rev", exp, d);
      chk("rd status", 8'h00, {6'h0, st[1:0]});
      chk("rd cmd byte", 8'hC9, mon_byte);
      chk("rd ack", 8'h00, {7'h0, mon_ack});
   endtask
   task automatic t_activate();
      logic [7:0] st;
      t_fw(`GSRP_FW_ZERO);
      link_wr(`GSRP_OFF_CONFIG, 8'h30, st);
      chk("half awake", 8'h00, {7'h0, active});
      t_fw(`GSRP_FW_ZERO);
      link_wr(`GSRP_OFF_CONFIG, 8'h00, st);
      chk("awake", 8'h01, {7'h0, active});
      t_fw({TB_PART, fw_level});
      link_wr(`GSRP_OFF_FWREV, 8'h00, st);
      t_fw({TB_PART, fw_level});
   endtask
   task automatic t_modes();
      logic [7:0] st, d, a;
      for (int m = 0; m < 2; m++) begin
         a = 8'h20 + 8'(m);
         sw_wr(`GSRP_H_MODE, 8'(m));
         min_per = 1000;
         link_wr(a, 8'hA5 ^ a, st);
         chk("wr status", 8'h00, {6'h0, st[1:0]});
         chk("wr cmd byte", 8'hC8, mon_byte);
         chk("ext byte", 8'hA5 ^ a, mem[a]);
         link_rd(a, d, st);
         chk("read back", 8'hA5 ^ a, d);
         chk("bit rate", 8'h01, {7'h0, min_per >= (m ? 24 : 99)});
      end
   endtask
   task automatic t_addr();
      logic [7:0] tab [4];
      logic [3:0] exp;
      logic       ack;
      tab = '{8'hC8, 8'hCA, 8'h48, 8'hC9};
      exp = 4'b0110;
      for (int k = 0; k < 4; k++) begin
         bb(1, 1);
         bb(1, 0);
         bb(0, 0);
         for (int i = 7; i >= 0; i--) begin
            bb(0, tab[k][i]);
            bb(1, tab[k][i]);
            bb(0, tab[k][i]);
         end
         bb(0, 1);
         bb(1, 1);
         ack = bus2.sda;
         chk("addr ack", {7'h0, exp[k]}, {7'h0, ack});
         bb(0, 0);
         bb(1, 0);
         bb(1, 1);
      end
   endtask

   initial begin
      num_errors = 0;
      n_checks = 0;
      mon_bits = 9;
      per_cnt = 0;
      min_per = 1000;
      rst_n = 1'b0;
      por_ok = 1'b0;
      fw_level = 6'h2D;
      cmd_addr = 3'h0;
      cmd_wdata = 8'h00;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      bus2.host_scl_out = 1'b0;
      bus2.host_sda_out = 1'b0;
      bus2.host_scl_oe = 1'b0;
      bus2.host_sda_oe = 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_reset();
      t_por();
      t_activate();
      t_modes();
      t_addr();
      close_out();
   end
endmodule

/* File: include/gsrp_defs.svh */
// constants shared by the gauge serial register port ends
`ifndef GSRP_DEFS_SVH
`define GSRP_DEFS_SVH

// ==================================================
// device address and register map
`define GSRP_SLAVE_ADDR     7'h64
`define GSRP_OFF_CONFIG     8'h08
`define GSRP_OFF_FWREV      8'hAB
`define GSRP_CONFIG_RESET   8'hF0
`define GSRP_CFG_SLEEP_HI   7
`define GSRP_CFG_SLEEP_LO   6
`define GSRP_CFG_RSTRT_HI   5
`define GSRP_CFG_RSTRT_LO   4
`define GSRP_FW_ZERO        8'h00

// ==================================================
// link timing
`define GSRP_CLK_NS         100
`define GSRP_STD_BIT_NS     10000
`define GSRP_FAST_BIT_NS    2500
`define GSRP_STD_QTR  ((`GSRP_STD_BIT_NS + 4*`GSRP_CLK_NS - 1) / (4*`GSRP_CLK_NS))
`define GSRP_FAST_QTR ((`GSRP_FAST_BIT_NS + 4*`GSRP_CLK_NS - 1) / (4*`GSRP_CLK_NS))

// ==================================================
// host command registers
`define GSRP_H_PTR          3'h0
`define GSRP_H_WDATA        3'h1
`define GSRP_H_CMD          3'h2
`define GSRP_H_STATUS       3'h3
`define GSRP_H_RDATA        3'h4
`define GSRP_H_MODE         3'h5
`define GSRP_CMD_WR_BIT     0
`define GSRP_CMD_RD_BIT     1

`endif

/* File: include/gsrp_if.sv */
// two-wire link between host master and gauge device
`timescale 1ns/10ps
interface gsrp_if;
   logic host_scl_out;
   logic host_scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // open-drain wired-and with pull-ups: an enabled low pulls the line
   assign scl = ~(host_scl_oe & ~host_scl_out);
   assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

   modport host (
      output host_scl_out,
      output host_scl_oe,
      output host_sda_out,
      output host_sda_oe,
      input  scl,
      input  sda
   );

   modport device (
      output dev_sda_out,
      output dev_sda_oe,
      input  scl,
      input  sda
   );
endinterface

/* File: include/gsrp_pkg.sv */
// types shared by the gauge serial register port ends
package gsrp_pkg;

   typedef enum logic [2:0] {
      GSRP_DS_IDLE = 3'b000,
      GSRP_DS_RX   = 3'b001,
      GSRP_DS_ACK  = 3'b010,
      GSRP_DS_TX   = 3'b011,
      GSRP_DS_MACK = 3'b100
   } gsrp_dstate_e;

   typedef enum logic [1:0] {
      GSRP_OP_START = 2'b00,
      GSRP_OP_TX    = 2'b01,
      GSRP_OP_RX    = 2'b10,
      GSRP_OP_STOP  = 2'b11
   } gsrp_op_e;

endpackage

/* File: verilog/gsrp_device.sv */
// gauge-side serial slave port with its config and firmware revision regs
// How it works
// R01: firmware revision reads zero during shutdown
// R02: active: identity in top bits, version below
// R03: device is slave only, never drives clock
// R04: standard and fast bit rates both supported
// R05: idle bus lines released, resting high
// R06: data changes only while clock is low
// R07: start/stop are data edges while clock high
// R08: master makes start and stop conditions
// R09: eight bits per byte, msb first
// R10: ninth pulse carries receiver acknowledge low
// R11: nack ends transfer by stop or restart
// R12: first byte is address plus direction bit
// R13: respond only to slave address 0x64
// R14: port silent until power-on reset passes
// R15: host writes 0x30 then 0x00 to activate
// R16: first write byte sets pointer, then increments
`timescale 1ns/10ps
`include "gsrp_defs.svh"
module gsrp_device
   import gsrp_pkg::*;
#(
   // arbitrary neutral value, not a real part code
   parameter logic [1:0] PART_ID = 2'h2
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   gsrp_if.device          bus,
   input  wire logic       por_ok,
   input  wire logic [5:0] fw_level,
   input  wire logic [7:0] ext_rdata,
   output logic [7:0]      ext_addr,
   output logic [7:0]      ext_wdata,
   output logic            ext_wr,
   output logic            active
);

   // ==================================================
   // pin sampling and bus events
   logic         scl_s;
   logic         sda_s;
   logic         por_s;
   logic         scl_p_reg;
   logic         sda_p_reg;
   logic         start_ev;
   logic         stop_ev;
   logic         scl_rise;
   logic         scl_fall;

   gsrp_sync #(.W(3)) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     ({bus.scl, bus.sda, por_ok}),
      .q     ({scl_s, sda_s, por_s})
   );

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         scl_p_reg <= 1'b1;
         sda_p_reg <= 1'b1;
      end else begin
         scl_p_reg <= scl_s;
         sda_p_reg <= sda_s;
      end
   end

   assign start_ev = scl_s && scl_p_reg && sda_p_reg && !sda_s; // R07
   assign stop_ev  = scl_s && scl_p_reg && !sda_p_reg && sda_s; // R07
   assign scl_rise = scl_s && !scl_p_reg;
   assign scl_fall = !scl_s && scl_p_reg;

   // ==================================================
   // byte engine
   gsrp_dstate_e state_reg;
   logic [3:0]   bit_reg;
   logic [7:0]   shift_reg;
   logic         is_addr_reg;
   logic         rw_reg;
   logic         nack_reg;
   logic         ptr_set_reg;
   logic         sda_oe_reg;
   logic [7:0]   ptr_reg;
   logic [7:0]   config_reg;
   logic         active_reg;
   logic         ext_wr_reg;
   logic [7:0]   ext_wdata_reg;
   logic         wr_step_reg;
   logic [7:0]   rd_byte;
   logic         byte_end;
   logic         addr_hit;
   logic         data_wr;
   logic         ptr_load;
   logic         tx_load;
   logic         reg_local;

   assign byte_end = (state_reg == GSRP_DS_RX) && scl_fall
                     && (bit_reg == 4'h8); // R09
   assign addr_hit = shift_reg[7:1] == `GSRP_SLAVE_ADDR; // R13
   assign data_wr  = byte_end && !is_addr_reg && ptr_set_reg;
   assign ptr_load = byte_end && !is_addr_reg && !ptr_set_reg; // R16
   assign tx_load  = scl_fall && rw_reg
                     && ((state_reg == GSRP_DS_ACK)
                         || ((state_reg == GSRP_DS_MACK) && !nack_reg));
   assign reg_local = (ptr_reg == `GSRP_OFF_CONFIG)
                      || (ptr_reg == `GSRP_OFF_FWREV);

   always_comb begin
      case (ptr_reg)
         `GSRP_OFF_FWREV:
            rd_byte = active_reg ? {PART_ID, fw_level} // R02
                                 : `GSRP_FW_ZERO;      // R01
         `GSRP_OFF_CONFIG:
            rd_byte = config_reg;
         default:
            rd_byte = ext_rdata;
      endcase
   end

   // por gate holds the engine idle with the data line released
   always_ff @(posedge clock) begin
      if (!rst_n || !por_s) begin // R14
         state_reg   <= GSRP_DS_IDLE;
         bit_reg     <= 4'h0;
         shift_reg   <= 8'h00;
         is_addr_reg <= 1'b0;
         rw_reg      <= 1'b0;
         nack_reg    <= 1'b0;
         ptr_set_reg <= 1'b0;
         sda_oe_reg  <= 1'b0; // R05
      end else if (start_ev) begin // R08
         state_reg   <= GSRP_DS_RX;
         bit_reg     <= 4'h0;
         is_addr_reg <= 1'b1; // R12
         ptr_set_reg <= 1'b0;
         sda_oe_reg  <= 1'b0;
      end else if (stop_ev) begin
         state_reg  <= GSRP_DS_IDLE;
         sda_oe_reg <= 1'b0; // R05
      end else begin
         unique case (state_reg)
            GSRP_DS_IDLE: begin
               sda_oe_reg <= 1'b0;
            end
            GSRP_DS_RX: begin
               if (scl_rise && (bit_reg != 4'h8)) begin
                  shift_reg <= {shift_reg[6:0], sda_s}; // R09
                  bit_reg   <= bit_reg + 4'h1;
               end
               if (byte_end) begin
                  is_addr_reg <= 1'b0;
                  if (is_addr_reg && !addr_hit) begin
                     state_reg <= GSRP_DS_IDLE; // R13
                  end else begin
                     state_reg  <= GSRP_DS_ACK;
                     sda_oe_reg <= 1'b1; // R10
                     if (is_addr_reg) begin
                        rw_reg <= shift_reg[0]; // R12
                     end else begin
                        ptr_set_reg <= 1'b1;
                     end
                  end
               end
            end
            GSRP_DS_ACK: begin
               if (scl_fall) begin
                  bit_reg <= 4'h0;
                  if (rw_reg) begin
                     state_reg  <= GSRP_DS_TX;
                     shift_reg  <= rd_byte;
                     sda_oe_reg <= ~rd_byte[7]; // R06
                  end else begin
                     state_reg  <= GSRP_DS_RX;
                     sda_oe_reg <= 1'b0;
                  end
               end
            end
            GSRP_DS_TX: begin
               if (scl_fall) begin
                  if (bit_reg == 4'h7) begin
                     state_reg  <= GSRP_DS_MACK;
                     sda_oe_reg <= 1'b0; // R10
                  end else begin
                     shift_reg  <= {shift_reg[6:0], 1'b0};
                     sda_oe_reg <= ~shift_reg[6]; // R06
                     bit_reg    <= bit_reg + 4'h1;
                  end
               end
            end
            GSRP_DS_MACK: begin
               if (scl_rise) begin
                  nack_reg <= sda_s; // R11
               end
               if (scl_fall) begin
                  bit_reg <= 4'h0;
                  if (nack_reg) begin
                     state_reg <= GSRP_DS_IDLE; // R11
                  end else begin
                     state_reg  <= GSRP_DS_TX;
                     shift_reg  <= rd_byte;
                     sda_oe_reg <= ~rd_byte[7];
                  end
               end
            end
            default: begin
               state_reg  <= GSRP_DS_IDLE;
               sda_oe_reg <= 1'b0;
            end
         endcase
      end
   end

   // ==================================================
   // register pointer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ptr_reg <= 8'h00;
      end else if (ptr_load) begin
         ptr_reg <= shift_reg; // R16
      // step only after the write strobe has left with the old pointer
      end else if (wr_step_reg || tx_load) begin
         ptr_reg <= ptr_reg + 8'h01; // R16
      end
   end

   // ==================================================
   // configuration and mode
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         config_reg <= `GSRP_CONFIG_RESET;
      end else if (data_wr && (ptr_reg == `GSRP_OFF_CONFIG)) begin
         config_reg <= shift_reg; // R15
      end
   end

   // active only once both sleep and restart fields are cleared
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         active_reg <= 1'b0;
      end else begin
         active_reg <= (config_reg[`GSRP_CFG_SLEEP_HI:`GSRP_CFG_SLEEP_LO]
                        == 2'h0)
                       && (config_reg[`GSRP_CFG_RSTRT_HI:`GSRP_CFG_RSTRT_LO]
                           == 2'h0); // R15
      end
   end

   // ==================================================
   // writes to registers kept outside this port
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ext_wr_reg    <= 1'b0;
         ext_wdata_reg <= 8'h00;
         wr_step_reg   <= 1'b0;
      end else begin
         ext_wr_reg <= data_wr && !reg_local;
         wr_step_reg <= data_wr;
         if (data_wr) begin
            ext_wdata_reg <= shift_reg;
         end
      end
   end

   // the device only ever pulls data low; it has no clock driver
   assign bus.dev_sda_out = 1'b0; // R03
   assign bus.dev_sda_oe  = sda_oe_reg;
   assign ext_addr        = ptr_reg;
   assign ext_wdata       = ext_wdata_reg;
   assign ext_wr          = ext_wr_reg;
   assign active          = active_reg;
endmodule

/* File: verilog/gsrp_host.sv */
// host-side master that runs single-byte register accesses on the link
`timescale 1ns/10ps
`include "gsrp_defs.svh"
module gsrp_host
   import gsrp_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   gsrp_if.host            bus,
   input  wire logic [2:0] cmd_addr,
   input  wire logic [7:0] cmd_wdata,
   input  wire logic       cmd_wr,
   input  wire logic       cmd_rd,
   output logic [7:0]      cmd_rdata
);

   // ==================================================
   // command registers
   logic [7:0] ptr_reg;
   logic [7:0] wdata_reg;
   logic       fast_reg;
   logic       busy_reg;
   logic       rd_reg;
   logic       nack_reg;
   logic [7:0] rdata_reg;
   logic [7:0] cmd_rdata_reg;
   logic       go;

   assign go = cmd_wr && (cmd_addr == `GSRP_H_CMD) && !busy_reg
               && (cmd_wdata[`GSRP_CMD_WR_BIT] || cmd_wdata[`GSRP_CMD_RD_BIT]);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ptr_reg   <= 8'h00;
         wdata_reg <= 8'h00;
         fast_reg  <= 1'b0;
      end else if (cmd_wr && !busy_reg) begin
         if (cmd_addr == `GSRP_H_PTR) ptr_reg <= cmd_wdata;
         if (cmd_addr == `GSRP_H_WDATA) wdata_reg <= cmd_wdata;
         if (cmd_addr == `GSRP_H_MODE) fast_reg <= cmd_wdata[0]; // R04
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cmd_rdata_reg <= 8'h00;
      end else if (cmd_rd) begin
         case (cmd_addr)
            `GSRP_H_PTR:    cmd_rdata_reg <= ptr_reg;
            `GSRP_H_WDATA:  cmd_rdata_reg <= wdata_reg;
            `GSRP_H_STATUS: cmd_rdata_reg <= {6'h00, nack_reg, busy_reg};
            `GSRP_H_RDATA:  cmd_rdata_reg <= rdata_reg;
            `GSRP_H_MODE:   cmd_rdata_reg <= {7'h00, fast_reg};
            default:        cmd_rdata_reg <= 8'h00;
         endcase
      end else begin
         cmd_rdata_reg <= 8'h00;
      end
   end

   // ==================================================
   // quarter-bit divider; bit time rounded up so rates stay at or below max
   logic [4:0] div_reg;
   logic [4:0] div_top;
   logic       tick;

   assign div_top = fast_reg ? 5'(`GSRP_FAST_QTR - 1)
                             : 5'(`GSRP_STD_QTR - 1); // R04
   assign tick    = busy_reg && (div_reg == div_top);

   always_ff @(posedge clock) begin
      if (!rst_n || !busy_reg || tick) begin
         div_reg <= 5'h00;
      end else begin
         div_reg <= div_reg + 5'h01;
      end
   end

   // ==================================================
   // transfer script
   logic       sda_s;
   logic [2:0] step_reg;
   logic [1:0] q_reg;
   logic [3:0] bit_reg;
   logic [7:0] shift_reg;
   logic       scl_oe_reg;
   logic       sda_oe_reg;
   gsrp_op_e   op;
   logic [7:0] tx_byte;
   logic [2:0] stop_step;

   gsrp_sync #(.W(1)) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     (bus.sda),
      .q     (sda_s)
   );

   // write: S addr+w ptr data P ; read: S addr+w ptr Sr addr+r byte P
   always_comb begin
      stop_step = rd_reg ? 3'h6 : 3'h4;
      if (step_reg == 3'h0 || (rd_reg && step_reg == 3'h3)) begin
         op = GSRP_OP_START; // R08
      end else if (step_reg == stop_step) begin
         op = GSRP_OP_STOP; // R08
      end else if (rd_reg && step_reg == 3'h5) begin
         op = GSRP_OP_RX;
      end else begin
         op = GSRP_OP_TX;
      end
      if (step_reg == 3'h1) begin
         tx_byte = {`GSRP_SLAVE_ADDR, 1'b0}; // R12
      end else if (step_reg == 3'h2) begin
         tx_byte = ptr_reg;
      end else if (step_reg == 3'h4) begin
         tx_byte = {`GSRP_SLAVE_ADDR, 1'b1}; // R12
      end else begin
         tx_byte = wdata_reg;
      end
   end

   // quarters: 0 set data with clock low, 1 raise clock, 2 sample, 3 lower
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_reg   <= 1'b0;
         rd_reg     <= 1'b0;
         nack_reg   <= 1'b0;
         rdata_reg  <= 8'h00;
         step_reg   <= 3'h0;
         q_reg      <= 2'h0;
         bit_reg    <= 4'h0;
         shift_reg  <= 8'h00;
         scl_oe_reg <= 1'b0; // R05
         sda_oe_reg <= 1'b0; // R05
      end else if (go) begin
         busy_reg <= 1'b1;
         rd_reg   <= cmd_wdata[`GSRP_CMD_RD_BIT];
         nack_reg <= 1'b0;
         step_reg <= 3'h0;
         q_reg    <= 2'h0;
         bit_reg  <= 4'h0;
      end else if (tick) begin
         q_reg <= q_reg + 2'h1;
         unique case (op)
            GSRP_OP_START: begin
               if (q_reg == 2'h0) sda_oe_reg <= 1'b0;
               if (q_reg == 2'h1) scl_oe_reg <= 1'b0;
               if (q_reg == 2'h2) sda_oe_reg <= 1'b1; // R07
               if (q_reg == 2'h3) begin
                  scl_oe_reg <= 1'b1;
                  step_reg   <= step_reg + 3'h1;
               end
            end
            GSRP_OP_TX, GSRP_OP_RX: begin
               if (q_reg == 2'h0) begin
                  sda_oe_reg <= (op == GSRP_OP_TX) && (bit_reg != 4'h8)
                                && !tx_byte[3'(4'h7 - bit_reg)]; // R06
               end
               if (q_reg == 2'h1) scl_oe_reg <= 1'b0;
               if (q_reg == 2'h2) begin
                  if (bit_reg == 4'h8) begin
                     if (op == GSRP_OP_TX) nack_reg <= sda_s; // R10
                  end else begin
                     shift_reg <= {shift_reg[6:0], sda_s}; // R09
                  end
               end
               if (q_reg == 2'h3) begin
                  scl_oe_reg <= 1'b1;
                  bit_reg    <= bit_reg + 4'h1;
                  if (bit_reg == 4'h8) begin
                     bit_reg <= 4'h0;
                     if (op == GSRP_OP_RX) rdata_reg <= shift_reg;
                     step_reg <= nack_reg ? stop_step
                                          : step_reg + 3'h1; // R11
                  end
               end
            end
            GSRP_OP_STOP: begin
               if (q_reg == 2'h0) sda_oe_reg <= 1'b1;
               if (q_reg == 2'h1) scl_oe_reg <= 1'b0;
               if (q_reg == 2'h2) sda_oe_reg <= 1'b0; // R07
               if (q_reg == 2'h3) busy_reg <= 1'b0; // R05
            end
         endcase
      end
   end

   assign bus.host_scl_out = 1'b0;
   assign bus.host_scl_oe  = scl_oe_reg;
   assign bus.host_sda_out = 1'b0;
   assign bus.host_sda_oe  = sda_oe_reg;
   assign cmd_rdata        = cmd_rdata_reg;
endmodule

/* File: verilog/gsrp_sync.sv */
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/10ps
module gsrp_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_reg;

   // idle bus levels are high, so reset to ones to avoid false edges
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_reg <= '1;
         q        <= '1;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
